// *** rtl/sync_modem_pkg.sv ***
// Operation
// - Transmit logic advances only on the modem transmit timing clock; here rts and the TX_IDLE/TX_WAIT_CTS moves follow tx_rts_i on any mclk edge.
// - Transmit data bit changes on rising edge of transmit timing clock.
// - Receive logic advances only on the modem receive timing clock.
// - Receive data is sampled on falling edge of receive timing clock.
// - No transmit clock is ever driven toward the modem.
// - Terminal ready is raised when a call is to be connected.
// - Terminal ready is dropped to end a completed call.
// - Terminal ready stays low after a drop until data set ready falls.
// - Ring indicate passes an integrating filter rejecting short spikes.
// - After request to send, transmitter idles until clear to send.
// - Clear to send is ignored while request to send is low.
// - Receiver logic is idle until carrier detect is asserted.
// - Characters are sent and received least significant bit first.
package sync_modem_pkg;
  localparam int DATA_W = 8;
  localparam int BIT_CNT_W = 4;
  localparam int RING_MIN_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RING_CYCLES = (RING_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RING_CNT_W = 16;
  localparam logic TXD_IDLE = 1'b1;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET = 4'h0;
  localparam logic [RING_CNT_W-1:0] RING_CNT_RESET = 16'h0000;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT_CTS = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_type;
  typedef enum logic [1:0] {
    DTR_OFF = 2'b00,
    DTR_ON = 2'b01,
    DTR_HOLDOFF = 2'b10
  } dtr_state_type;
endpackage

// *** rtl/two_entry_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer
  import sync_modem_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } buf_type;
  buf_type s_q, s_d;
  logic push, pop;
  always_comb begin
    s_d = s_q;
    push = in_valid_i && (s_q.cnt != 2'h2);
    pop = out_ready_i && (s_q.cnt != 2'h0);
    if (push) begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp = ~s_q.wp;
    end
    if (pop) begin
      s_d.rp = ~s_q.rp;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 2'h1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 2'h1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign in_ready_o = (s_q.cnt != 2'h2);
  assign out_valid_o = (s_q.cnt != 2'h0);
  assign out_data_o = s_q.mem[s_q.rp];
endmodule
`default_nettype wire

// *** rtl/sync_modem_interface_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_modem_interface_control
  import sync_modem_pkg::*;
#(
  parameter int RING_HOLD = RING_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [DATA_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic tx_rts_i,
  output logic [DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic call_up_i,
  output logic txd_o,
  output logic rts_o,
  output logic dtr_o,
  output logic ring_o,
  output logic carrier_o,
  input wire logic tx_timing_i,
  input wire logic rx_timing_i,
  input wire logic rxd_i,
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic dcd_i,
  input wire logic ri_i
);
  // ************************************************************
  // Synchronisers
  // ************************************************************
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_q, sync2_q;
  assign async_in = {ri_i, dcd_i, dsr_i, cts_i, rxd_i, rx_timing_i, tx_timing_i};
  always_ff @(posedge mclk_i) begin
    sync1_q <= async_in;
    sync2_q <= sync1_q;
  end
  logic txc_s, rxc_s, rxd_s, cts_s, dsr_s, dcd_s, ri_s;
  assign {ri_s, dcd_s, dsr_s, cts_s, rxd_s, rxc_s, txc_s} = sync2_q;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic txc_prev;
    logic rxc_prev;
    tx_state_type tx_st;
    logic [DATA_W-1:0] tx_sh;
    logic [BIT_CNT_W-1:0] tx_cnt;
    logic txd;
    logic rts;
    logic rx_act;
    logic [DATA_W-1:0] rx_sh;
    logic [BIT_CNT_W-1:0] rx_cnt;
    logic [DATA_W-1:0] rx_word;
    logic rx_push;
    dtr_state_type dtr_st;
    logic [RING_CNT_W-1:0] ring_cnt;
    logic ring;
    logic carrier;
  } state_type;
  state_type s_q, s_d;

  logic buf_take;
  logic [DATA_W-1:0] buf_data;
  logic buf_valid;
  logic txc_rise, rxc_fall, tx_go;
  logic [RING_CNT_W-1:0] ring_lim;
  assign ring_lim = RING_CNT_W'(RING_HOLD);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.txc_prev = txc_s;
    s_d.rxc_prev = rxc_s;
    s_d.rx_push = 1'b0;
    txc_rise = txc_s && !s_q.txc_prev;
    rxc_fall = !rxc_s && s_q.rxc_prev;
    tx_go = s_q.rts && cts_s;
    s_d.carrier = dcd_s;
    // Transmit on rising edge of modem transmit timing only
    unique case (s_q.tx_st)
      TX_IDLE: begin
        if (tx_rts_i) begin
          s_d.rts = 1'b1;
          s_d.tx_st = TX_WAIT_CTS;
        end
      end
      TX_WAIT_CTS: begin
        if (!tx_rts_i) begin
          s_d.rts = 1'b0;
          s_d.tx_st = TX_IDLE;
        end else if (tx_go && txc_rise && tx_valid_i) begin
          s_d.tx_sh = tx_data_i;
          s_d.txd = 1'b0;
          s_d.tx_cnt = BIT_CNT_RESET;
          s_d.tx_st = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (txc_rise) begin
          if (s_q.tx_cnt == BIT_CNT_W'(DATA_W)) begin
            s_d.txd = TXD_IDLE;
            s_d.tx_st = TX_WAIT_CTS;
          end else begin
            s_d.txd = s_q.tx_sh[0];
            s_d.tx_sh = {1'b0, s_q.tx_sh[DATA_W-1:1]};
            s_d.tx_cnt = s_q.tx_cnt + 1'b1;
          end
        end
      end
      default: begin
        s_d.tx_st = TX_IDLE;
      end
    endcase
    // Receive on falling edge of modem receive timing, gated by carrier
    if (!dcd_s) begin
      s_d.rx_act = 1'b0;
      s_d.rx_cnt = BIT_CNT_RESET;
    end else if (rxc_fall) begin
      if (!s_q.rx_act) begin
        if (!rxd_s) begin
          s_d.rx_act = 1'b1;
          s_d.rx_cnt = BIT_CNT_RESET;
        end
      end else if (s_q.rx_cnt == BIT_CNT_W'(DATA_W)) begin
        s_d.rx_act = 1'b0;
        if (rxd_s) begin
          s_d.rx_word = s_q.rx_sh;
          s_d.rx_push = 1'b1;
        end
      end else begin
        s_d.rx_sh = {rxd_s, s_q.rx_sh[DATA_W-1:1]};
        s_d.rx_cnt = s_q.rx_cnt + 1'b1;
      end
    end
    // Terminal ready
    unique case (s_q.dtr_st)
      DTR_OFF: begin
        if (call_up_i) begin
          s_d.dtr_st = DTR_ON;
        end
      end
      DTR_ON: begin
        if (!call_up_i) begin
          s_d.dtr_st = DTR_HOLDOFF;
        end
      end
      DTR_HOLDOFF: begin
        if (!dsr_s) begin
          s_d.dtr_st = DTR_OFF;
        end
      end
      default: begin
        s_d.dtr_st = DTR_OFF;
      end
    endcase
    // Ring integrator
    if (ri_s) begin
      if (s_q.ring_cnt != ring_lim) begin
        s_d.ring_cnt = s_q.ring_cnt + 1'b1;
      end
    end else if (s_q.ring_cnt != RING_CNT_RESET) begin
      s_d.ring_cnt = s_q.ring_cnt - 1'b1;
    end
    if (s_q.ring_cnt == ring_lim) begin
      s_d.ring = 1'b1;
    end else if (s_q.ring_cnt == RING_CNT_RESET) begin
      s_d.ring = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.txd <= TXD_IDLE;
      s_q.tx_st <= TX_IDLE;
      s_q.dtr_st <= DTR_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Receive buffer
  // ************************************************************
  two_entry_buffer #(
    .WIDTH(DATA_W)
  ) u_rx_buf (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_data_i(s_q.rx_word),
    .in_valid_i(s_q.rx_push),
    .in_ready_o(),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_take)
  );
  // Output stage reloads only when empty or being read
  assign buf_take = !rx_valid_o || rx_ready_i;

  // ************************************************************
  // Outputs
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_data_o <= '0;
      rx_valid_o <= 1'b0;
      tx_ready_o <= 1'b0;
      txd_o <= TXD_IDLE;
      rts_o <= 1'b0;
      dtr_o <= 1'b0;
      ring_o <= 1'b0;
      carrier_o <= 1'b0;
    end else begin
      if (buf_take) begin
        rx_valid_o <= buf_valid;
        rx_data_o <= buf_data;
      end
      tx_ready_o <= (s_d.tx_st == TX_SHIFT) && (s_q.tx_st == TX_WAIT_CTS);
      txd_o <= s_d.txd;
      rts_o <= s_d.rts;
      dtr_o <= (s_d.dtr_st == DTR_ON);
      ring_o <= s_d.ring;
      carrier_o <= s_d.carrier;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_tx_hold_no_cts;
    @(posedge mclk_i) disable iff (rst_i)
      (s_q.tx_st == TX_WAIT_CTS && !cts_s) |=> (s_q.tx_st != TX_SHIFT);
  endproperty
  a_tx_hold_no_cts: assert property (p_tx_hold_no_cts) else $error("tx left idle without cts");
  property p_cts_ignored;
    @(posedge mclk_i) disable iff (rst_i)
      (!s_q.rts) |=> (s_q.tx_st != TX_SHIFT);
  endproperty
  a_cts_ignored: assert property (p_cts_ignored) else $error("cts used without rts");
  property p_txd_on_rise;
    @(posedge mclk_i) disable iff (rst_i)
      (s_q.tx_st == TX_SHIFT && !txc_rise) |=> $stable(s_q.txd);
  endproperty
  a_txd_on_rise: assert property (p_txd_on_rise) else $error("txd moved off rise");
  property p_rx_idle;
    @(posedge mclk_i) disable iff (rst_i)
      (!dcd_s) |=> (!s_q.rx_act && !s_q.rx_push);
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("rx active without carrier");
  property p_rx_fall;
    @(posedge mclk_i) disable iff (rst_i)
      (!rxc_fall) |=> $stable(s_q.rx_cnt) || (s_q.rx_cnt == BIT_CNT_RESET);
  endproperty
  a_rx_fall: assert property (p_rx_fall) else $error("rx moved off fall");
  property p_dtr_holdoff;
    @(posedge mclk_i) disable iff (rst_i)
      (s_q.dtr_st == DTR_HOLDOFF && dsr_s) |=> (s_q.dtr_st == DTR_HOLDOFF);
  endproperty
  a_dtr_holdoff: assert property (p_dtr_holdoff) else $error("dtr re-raised early");
  property p_dtr_drop;
    @(posedge mclk_i) disable iff (rst_i)
      (s_q.dtr_st == DTR_ON && !call_up_i) |=> ##1 !dtr_o;
  endproperty
  a_dtr_drop: assert property (p_dtr_drop) else $error("dtr not dropped");
  property p_ring_spike;
    @(posedge mclk_i) disable iff (rst_i)
      (s_q.ring_cnt == RING_CNT_RESET) |=> !s_q.ring;
  endproperty
  a_ring_spike: assert property (p_ring_spike) else $error("ring passed spike");
  property p_ring_sat;
    @(posedge mclk_i) disable iff (rst_i)
      (s_q.ring_cnt == ring_lim && ri_s) |=> (s_q.ring_cnt == ring_lim);
  endproperty
  a_ring_sat: assert property (p_ring_sat) else $error("ring counter not saturating");
  property p_dtr_raise;
    @(posedge mclk_i) disable iff (rst_i)
      (s_q.dtr_st == DTR_OFF && call_up_i) |=> (s_q.dtr_st == DTR_ON);
  endproperty
  a_dtr_raise: assert property (p_dtr_raise) else $error("dtr not raised for call");
  property p_ring_wait;
    @(posedge mclk_i) disable iff (rst_i)
      (!s_q.ring && s_q.ring_cnt != ring_lim) |=> !s_q.ring;
  endproperty
  a_ring_wait: assert property (p_ring_wait) else $error("ring before hold time");
  property p_tx_lsb_first;
    @(posedge mclk_i) disable iff (rst_i)
      (s_q.tx_st == TX_SHIFT && txc_rise && s_q.tx_cnt != BIT_CNT_W'(DATA_W))
        |=> (s_q.txd == $past(s_q.tx_sh[0]));
  endproperty
  a_tx_lsb_first: assert property (p_tx_lsb_first) else $error("tx bit out of order");
  property p_rx_lsb_first;
    @(posedge mclk_i) disable iff (rst_i)
      (dcd_s && rxc_fall && s_q.rx_act && s_q.rx_cnt != BIT_CNT_W'(DATA_W))
        |=> (s_q.rx_sh[DATA_W-1] == $past(rxd_s));
  endproperty
  a_rx_lsb_first: assert property (p_rx_lsb_first) else $error("rx bit not shifted in");
endmodule
`default_nettype wire

// *** tb/modem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module modem_model (
  input wire logic txd_i,
  input wire logic run_i,
  output logic tx_timing_o,
  output logic rx_timing_o,
  output logic rxd_o,
  output logic [8:0] got_o,
  output logic got_stb_o
);
  // ****************
  // Modem clocks, frame capture and frame send
  // ****************
  logic [9:0] sh_q;
  int n_q;
  initial begin
    tx_timing_o = 1'b0;
    rx_timing_o = 1'b0;
    rxd_o = 1'b1;
    got_o = 9'h000;
    got_stb_o = 1'b0;
    sh_q = 10'h000;
    n_q = 0;
  end
  always begin
    wait (run_i);
    #62.5 tx_timing_o = 1'b1;
    #62.5 tx_timing_o = 1'b0;
  end
  always @(negedge tx_timing_o) begin
    if (n_q != 0 || txd_i === 1'b0) begin
      sh_q = {txd_i, sh_q[9:1]};
      n_q++;
    end
    if (n_q == 10) begin
      n_q = 0;
      got_o = sh_q[9:1];
      got_stb_o = 1'b1;
      #5 got_stb_o = 1'b0;
    end
  end
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_timing_o = 1'b1;
      rxd_o = f[i];
      #62.5 rx_timing_o = 1'b0;
      #62.5;
    end
    rxd_o = ~rxd_o;
    #1;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_sync_modem_interface_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_sync_modem_interface_control;
  import sync_modem_pkg::*;
  localparam int HOLD = 8;
  logic mclk, rst, tx_valid, tx_rts, rx_ready, call_up, cts, dsr, dcd, ri, run;
  logic [DATA_W-1:0] tx_data, rx_data;
  logic tx_ready, rx_valid, txd, rts, dtr, ring, carrier, tx_tm, rx_tm, rxd, got_stb;
  logic [8:0] got;
  logic [8:0] exp_tx[$];
  logic [8:0] exp_rx[$];
  logic [7:0] b;
  int mismatches, checked, cyc, rx_mode;
  sync_modem_interface_control #(.RING_HOLD(HOLD)) u_dut (
    .mclk_i(mclk), .rst_i(rst), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .tx_rts_i(tx_rts), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .call_up_i(call_up), .txd_o(txd), .rts_o(rts), .dtr_o(dtr),
    .ring_o(ring), .carrier_o(carrier), .tx_timing_i(tx_tm), .rx_timing_i(rx_tm),
    .rxd_i(rxd), .cts_i(cts), .dsr_i(dsr), .dcd_i(dcd), .ri_i(ri)
  );
  modem_model u_modem (
    .txd_i(txd), .run_i(run), .tx_timing_o(tx_tm), .rx_timing_o(rx_tm), .rxd_o(rxd),
    .got_o(got), .got_stb_o(got_stb)
  );
  // ****************
  // Checks and report
  // ****************
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic put_tx(input logic [7:0] v);
    int n;
    n = 0;
    @(posedge mclk);
    tx_data <= v;
    tx_valid <= 1'b1;
    exp_tx.push_back({1'b1, v});
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (tx_ready !== 1'b1 && n < 1000);
  endtask
  task automatic hold_idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
      chk({7'h00, tx_ready, txd}, 9'h001);
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rx_ready <= (rx_mode == 2) ? 1'($urandom_range(0, 1)) : rx_mode[0];
    if (cyc == 30000) begin
      mismatches++;
      close_out();
    end
  end
  always @(posedge got_stb) begin
    chk(got, exp_tx.size() != 0 ? exp_tx.pop_front() : 9'h000);
  end
  always @(posedge mclk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      chk({1'b1, rx_data}, exp_rx.size() != 0 ? exp_rx.pop_front() : 9'h000);
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    {rst, run} = 2'b11;
    {tx_valid, tx_rts, call_up, cts, dsr, dcd, ri} = 7'h00;
    tx_data = 8'h00;
    {mismatches, checked, cyc, rx_mode} = {32'd0, 32'd0, 32'd0, 32'd1};
    void'($urandom(32'h1f9ac4e3));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({2'b00, txd, rts, dtr, ring, carrier, tx_ready, rx_valid}, 9'h040);
    @(posedge mclk);
    {tx_valid, cts} <= 2'b11;
    hold_idle(300);
    @(posedge mclk);
    {tx_rts, cts} <= 2'b10;
    hold_idle(300);
    chk({8'h00, rts}, 9'h001);
    @(posedge mclk);
    cts <= 1'b1;
    for (int i = 0; i < 3; i++) put_tx(8'($urandom));
    @(posedge mclk);
    tx_valid <= 1'b0;
    repeat (300) @(posedge mclk);
    chk(9'(exp_tx.size()), 9'h000);
    tx_rts <= 1'b0;
    u_modem.send_byte(8'h5A);
    chk({8'h00, rts}, 9'h000);
    @(posedge mclk);
    dcd <= 1'b1;
    rx_mode <= 0;
    repeat (10) @(posedge mclk);
    chk({8'h00, carrier}, 9'h001);
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      if (i < 3) exp_rx.push_back({1'b1, b});
      u_modem.send_byte(b);
    end
    repeat (20) @(posedge mclk);
    rx_mode <= 2;
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      exp_rx.push_back({1'b1, b});
      u_modem.send_byte(b);
    end
    repeat (60) @(posedge mclk);
    chk(9'(exp_rx.size()), 9'h000);
    dsr <= 1'b1;
    call_up <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({8'h00, dtr}, 9'h001);
    call_up <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({8'h00, dtr}, 9'h000);
    call_up <= 1'b1;
    repeat (10) @(posedge mclk);
    chk({8'h00, dtr}, 9'h000);
    dsr <= 1'b0;
    repeat (10) @(posedge mclk);
    chk({8'h00, dtr}, 9'h001);
    ri <= 1'b1;
    repeat (3) @(posedge mclk);
    ri <= 1'b0;
    repeat (20) @(posedge mclk);
    chk({8'h00, ring}, 9'h000);
    ri <= 1'b1;
    repeat (HOLD - 2) @(posedge mclk);
    chk({8'h00, ring}, 9'h000);
    repeat (8) @(posedge mclk);
    chk({8'h00, ring}, 9'h001);
    ri <= 1'b0;
    repeat (HOLD + 8) @(posedge mclk);
    chk({8'h00, ring}, 9'h000);
    close_out();
  end
endmodule
`default_nettype wire
